// >>> mifc_pkg.sv
// constants shared by the interrupt flag controller files
// Summary of operation
// - group register: group flags 7:4, enables 3:0
// - timebase/line register: line5,line4,tb1,tb0 flags then enables
// - serial register: sim,uart1,uart0 at 6:4 and 2:0
// - periodic timer group: 1A,1P,0A,0P flags then enables
// - voltage group: lvd,eeprom,stimer A,P flags then enables
// - audio timer group: B,A,P at 6:4 and 2:0
// - line group: line3,line2 at 5:4 and 1:0
// - events set flags regardless of enable
// - global enable low blocks all vectoring
// - take pushes pc, loads vector address
// - return pops saved pc and resumes
// - accepting interrupt clears global enable
// - flags still latch while interrupts blocked
// - no acknowledge while return stack full
// - any flag rising wakes the device
// - source flag set also sets group flag
// - group service clears only group flag
// - grouped source needs global, own, group enable
// - line 4/5 service clears their flags
package mifc_pkg;
    localparam int          NREG       = 7;
    localparam int          REG_W      = 8;
    localparam int          PC_W       = 16;
    localparam int          NSRC       = 11;
    localparam int          SRC_W      = 4;
    localparam int          FLAG_LSB   = 4;
    localparam logic [7:0]  RESET_VAL  = 8'h00;

    // register indices in the special-purpose data space
    localparam logic [2:0]  IDX_GROUP  = 3'h0;
    localparam logic [2:0]  IDX_TBEXT  = 3'h1;
    localparam logic [2:0]  IDX_SERIAL = 3'h2;
    localparam logic [2:0]  IDX_PTIMER = 3'h3;
    localparam logic [2:0]  IDX_VET    = 3'h4;
    localparam logic [2:0]  IDX_ATIMER = 3'h5;
    localparam logic [2:0]  IDX_EXTGRP = 3'h6;

    // implemented bits per register, index 6 in the top byte
    localparam logic [55:0] REG_MASKS  = 56'h33_77_FF_FF_77_FF_FF;

    // source numbers, also the priority order (low wins)
    localparam logic [3:0]  SRC_EXT4   = 4'h0;
    localparam logic [3:0]  SRC_EXT5   = 4'h1;
    localparam logic [3:0]  SRC_GRP0   = 4'h2;
    localparam logic [3:0]  SRC_GRP1   = 4'h3;
    localparam logic [3:0]  SRC_GRP2   = 4'h4;
    localparam logic [3:0]  SRC_GRP3   = 4'h5;
    localparam logic [3:0]  SRC_TB0    = 4'h6;
    localparam logic [3:0]  SRC_TB1    = 4'h7;
    localparam logic [3:0]  SRC_UART0  = 4'h8;
    localparam logic [3:0]  SRC_UART1  = 4'h9;
    localparam logic [3:0]  SRC_SIM    = 4'hA;

    localparam logic [15:0] VEC_BASE   = 16'h0004;
    localparam logic [15:0] VEC_STEP   = 16'h0004;
endpackage

// >>> mifc_flag_reg.sv
// one byte of request flags and enables with hardware set and clear
module mifc_flag_reg #(
    parameter logic [7:0] MASK = 8'hFF
) (
    input  wire logic       clk_i,    // system clock
    input  wire logic       nrst_i,   // async reset, active low
    input  wire logic       wr_i,     // software write strobe
    input  wire logic [7:0] wdata_i,  // software write data
    input  wire logic [7:0] set_i,    // hardware set, wins over all
    input  wire logic [7:0] clr_i,    // hardware clear on service
    output logic      [7:0] q_o       // register contents
);
    logic [7:0] next_q;

    // set beats both clears so no event is lost in a clearing cycle
    always_comb begin
        next_q = (set_i | (wr_i ? wdata_i : (q_o & ~clr_i))) & MASK;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_o <= mifc_pkg::RESET_VAL;
        end else begin
            q_o <= next_q;
        end
    end
endmodule

// >>> mifc_prio_enc.sv
// fixed priority picker, lowest index wins
module mifc_prio_enc #(
    parameter int N = 11,
    parameter int W = 4
) (
    input  wire logic [N-1:0] req_i,    // candidate requests
    output logic              valid_o,  // any request present
    output logic      [W-1:0] idx_o     // winning index
);
    always_comb begin
        valid_o = 1'b0;
        idx_o   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                valid_o = 1'b1;
                idx_o   = W'(i);
            end
        end
    end
endmodule

// >>> mifc_ctrl.sv
// interrupt request flags, enables, vectoring and wake-up of the core
module mifc_ctrl (
    input  wire logic        clk_i,           // system clock
    input  wire logic        nrst_i,          // async reset, active low
    input  wire logic        reg_wr_i,        // register write strobe
    input  wire logic        reg_rd_i,        // register read strobe
    input  wire logic [2:0]  reg_idx_i,       // register index
    input  wire logic [7:0]  reg_wdata_i,     // register write data
    output logic      [7:0]  reg_rdata_o,     // register read data
    input  wire logic        irq_en_set_i,    // software sets global enable
    input  wire logic        irq_en_clr_i,    // software clears global enable
    output logic             global_irq_enable_o, // global enable state
    input  wire logic [1:0]  tb_evt_i,        // time base 1..0 events
    input  wire logic [3:0]  ext_evt_i,       // lines 5..2 edge events
    input  wire logic [1:0]  uart_evt_i,      // uart 1..0 events
    input  wire logic        serial_evt_i,    // serial interface event
    input  wire logic [3:0]  ptimer_evt_i,    // 1A,1P,0A,0P matches
    input  wire logic [3:0]  vet_evt_i,       // lvd,eeprom,stimer A,P
    input  wire logic [2:0]  atimer_evt_i,    // audio timer B,A,P
    input  wire logic        insn_boundary_i, // core may be interrupted now
    input  wire logic        stack_full_i,    // return stack full
    input  wire logic [15:0] pc_i,            // next instruction address
    input  wire logic        irq_return_i,    // return-from-irq executed
    input  wire logic [15:0] stack_top_i,     // top of return stack
    output logic             push_o,          // push pc onto stack
    output logic      [15:0] push_data_o,     // pc value to push
    output logic             pop_o,           // pop return stack
    output logic             pc_load_o,       // load program counter
    output logic      [15:0] pc_load_addr_o,  // new program counter
    output logic      [3:0]  irq_src_o,       // source last taken
    output logic             wake_o           // leave sleep or idle
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  q     [mifc_pkg::NREG];
    logic [7:0]  set_v [mifc_pkg::NREG];
    logic [7:0]  clr_v [mifc_pkg::NREG];
    logic [3:0]  grp_set;
    logic [3:0]  src_any;
    logic [10:0] cand;
    logic [10:0] take_oh;
    logic        cand_valid;
    logic [3:0]  cand_idx;
    logic [15:0] cand_vec;
    logic        take;
    logic        irq_en;
    logic [27:0] flags_now;
    logic [27:0] flags_prev;

    genvar k;
    generate
        for (k = 0; k < mifc_pkg::NREG; k++) begin : g_reg
            // byte layouts follow the masks and set/clear wiring below
            mifc_flag_reg #(
                .MASK (mifc_pkg::REG_MASKS[k*8 +: 8])
            ) u_reg (
                .clk_i   (clk_i),
                .nrst_i  (nrst_i),
                .wr_i    (reg_wr_i && (reg_idx_i == 3'(k))),
                .wdata_i (reg_wdata_i),
                .set_i   (set_v[k]),
                .clr_i   (clr_v[k]),
                .q_o     (q[k])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // group membership: any member event marks the group
    always_comb begin
        grp_set[0] = |ptimer_evt_i;
        grp_set[1] = |vet_evt_i;
        grp_set[2] = |atimer_evt_i;
        grp_set[3] = |ext_evt_i[1:0];
    end

    // events set flags whatever the enables or global state say
    always_comb begin
        set_v[mifc_pkg::IDX_GROUP]  = {grp_set, 4'h0};
        set_v[mifc_pkg::IDX_TBEXT]  = {ext_evt_i[3:2], tb_evt_i, 4'h0};
        set_v[mifc_pkg::IDX_SERIAL] = {1'b0, serial_evt_i, uart_evt_i, 4'h0};
        set_v[mifc_pkg::IDX_PTIMER] = {ptimer_evt_i, 4'h0};
        set_v[mifc_pkg::IDX_VET]    = {vet_evt_i, 4'h0};
        set_v[mifc_pkg::IDX_ATIMER] = {1'b0, atimer_evt_i, 4'h0};
        set_v[mifc_pkg::IDX_EXTGRP] = {2'h0, ext_evt_i[1:0], 4'h0};
    end

    ////////////////////////////////////////////////////////////////////////
    // a group counts only with a member both flagged and enabled
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            src_any[g] = |(q[g + 3][7:4] & q[g + 3][3:0]);
        end
    end

    always_comb begin
        cand = '0;
        cand[mifc_pkg::SRC_EXT4]  = q[mifc_pkg::IDX_TBEXT][6] & q[mifc_pkg::IDX_TBEXT][2];
        cand[mifc_pkg::SRC_EXT5]  = q[mifc_pkg::IDX_TBEXT][7] & q[mifc_pkg::IDX_TBEXT][3];
        cand[mifc_pkg::SRC_TB0]   = q[mifc_pkg::IDX_TBEXT][4] & q[mifc_pkg::IDX_TBEXT][0];
        cand[mifc_pkg::SRC_TB1]   = q[mifc_pkg::IDX_TBEXT][5] & q[mifc_pkg::IDX_TBEXT][1];
        cand[mifc_pkg::SRC_UART0] = q[mifc_pkg::IDX_SERIAL][4] & q[mifc_pkg::IDX_SERIAL][0];
        cand[mifc_pkg::SRC_UART1] = q[mifc_pkg::IDX_SERIAL][5] & q[mifc_pkg::IDX_SERIAL][1];
        cand[mifc_pkg::SRC_SIM]   = q[mifc_pkg::IDX_SERIAL][6] & q[mifc_pkg::IDX_SERIAL][2];
        for (int g = 0; g < 4; g++) begin
            cand[int'(mifc_pkg::SRC_GRP0) + g] = q[mifc_pkg::IDX_GROUP][4 + g]
                & q[mifc_pkg::IDX_GROUP][g] & src_any[g];
        end
    end

    mifc_prio_enc #(
        .N (mifc_pkg::NSRC),
        .W (mifc_pkg::SRC_W)
    ) u_prio (
        .req_i   (cand),
        .valid_o (cand_valid),
        .idx_o   (cand_idx)
    );

    assign cand_vec = mifc_pkg::VEC_BASE + 16'(cand_idx) * mifc_pkg::VEC_STEP;

    // a return in the same cycle goes first; the request waits a cycle
    assign take = cand_valid && irq_en && !stack_full_i
               && insn_boundary_i && !irq_return_i;
    assign take_oh = take ? (11'h001 << cand_idx) : 11'h000;

    ////////////////////////////////////////////////////////////////////////
    // only the group flag and own-vector flags clear on service;
    // grouped source flags are left for software
    always_comb begin
        for (int r = 0; r < mifc_pkg::NREG; r++) begin
            clr_v[r] = 8'h00;
        end
        clr_v[mifc_pkg::IDX_GROUP] = {take_oh[mifc_pkg::SRC_GRP3],
                                      take_oh[mifc_pkg::SRC_GRP2],
                                      take_oh[mifc_pkg::SRC_GRP1],
                                      take_oh[mifc_pkg::SRC_GRP0], 4'h0};
        clr_v[mifc_pkg::IDX_TBEXT] = {take_oh[mifc_pkg::SRC_EXT5],
                                      take_oh[mifc_pkg::SRC_EXT4],
                                      take_oh[mifc_pkg::SRC_TB1],
                                      take_oh[mifc_pkg::SRC_TB0], 4'h0};
        clr_v[mifc_pkg::IDX_SERIAL] = {1'b0, take_oh[mifc_pkg::SRC_SIM],
                                       take_oh[mifc_pkg::SRC_UART1],
                                       take_oh[mifc_pkg::SRC_UART0], 4'h0};
    end

    ////////////////////////////////////////////////////////////////////////
    // acceptance beats a software set in the same cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_en <= 1'b0;
        end else if (take) begin
            irq_en <= 1'b0;
        end else if (irq_en_set_i) begin
            irq_en <= 1'b1;
        end else if (irq_en_clr_i) begin
            irq_en <= 1'b0;
        end
    end
    assign global_irq_enable_o = irq_en;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            push_o         <= 1'b0;
            push_data_o    <= 16'h0000;
            pop_o          <= 1'b0;
            pc_load_o      <= 1'b0;
            pc_load_addr_o <= 16'h0000;
            irq_src_o      <= 4'h0;
        end else begin
            push_o    <= take;
            pop_o     <= irq_return_i;
            pc_load_o <= take || irq_return_i;
            if (irq_return_i) begin
                pc_load_addr_o <= stack_top_i;
            end else if (take) begin
                push_data_o    <= pc_i;
                pc_load_addr_o <= cand_vec;
                irq_src_o      <= cand_idx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unmapped indices read zero; data held until the next read
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= (32'(reg_idx_i) < mifc_pkg::NREG) ? q[reg_idx_i] : 8'h00;
        end
    end

    // wake on a flag rising only; a flag already set before sleep stays
    // quiet, which is how software masks a wake source
    always_comb begin
        for (int r = 0; r < mifc_pkg::NREG; r++) begin
            flags_now[r*4 +: 4] = q[r][7:4];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_prev <= '0;
            wake_o     <= 1'b0;
        end else begin
            flags_prev <= flags_now;
            wake_o     <= |(flags_now & ~flags_prev);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_take;
        take;
    endsequence

    sequence s_vector_loaded;
        push_o && pc_load_o && !pop_o && !global_irq_enable_o;
    endsequence

    property p_en_blocks;
        !global_irq_enable_o |=> !push_o;
    endproperty
    a_en_blocks: assert property (p_en_blocks) else $error("take while disabled");

    property p_take_vectors;
        s_take |=> s_vector_loaded ##0 (push_data_o == $past(pc_i))
            ##0 (pc_load_addr_o == $past(cand_vec));
    endproperty
    a_take_vectors: assert property (p_take_vectors) else $error("vector load wrong");

    property p_take_clr_en;
        take && !irq_en_set_i |=> !global_irq_enable_o [*2] or irq_en_set_i;
    endproperty
    a_take_clr_en: assert property (p_take_clr_en) else $error("enable not cleared");

    property p_stack_full;
        stack_full_i |=> !push_o;
    endproperty
    a_stack_full: assert property (p_stack_full) else $error("take with stack full");

    property p_return_pop;
        irq_return_i |=> pop_o && pc_load_o && !push_o && pc_load_addr_o == $past(stack_top_i);
    endproperty
    a_return_pop: assert property (p_return_pop) else $error("return did not pop");

    property p_flag_sets;
        tb_evt_i[0] |=> q[mifc_pkg::IDX_TBEXT][4];
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("event lost");

    property p_group_sets;
        |ptimer_evt_i |=> q[mifc_pkg::IDX_GROUP][4] && q[mifc_pkg::IDX_PTIMER][7:4] != 4'h0;
    endproperty
    a_group_sets: assert property (p_group_sets) else $error("group flag not set");

    property p_group_clear;
        take && cand_idx == mifc_pkg::SRC_GRP1 && vet_evt_i == 4'h0 && !reg_wr_i
            |=> !q[mifc_pkg::IDX_GROUP][5] && q[mifc_pkg::IDX_VET] == $past(q[mifc_pkg::IDX_VET]);
    endproperty
    a_group_clear: assert property (p_group_clear) else $error("group service clear wrong");

    property p_priority;
        take |-> cand[cand_idx] && ((cand & ((11'h001 << cand_idx) - 11'h001)) == 11'h000);
    endproperty
    a_priority: assert property (p_priority) else $error("lower source passed over");

    property p_wake;
        $rose(q[mifc_pkg::IDX_SERIAL][4]) |=> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on flag rise");

    // with the enable low nothing is taken, so only a register write may clear a flag
    property p_flag_kept;
        !global_irq_enable_o && q[mifc_pkg::IDX_SERIAL][4] && !reg_wr_i
            |=> q[mifc_pkg::IDX_SERIAL][4];
    endproperty
    a_flag_kept: assert property (p_flag_kept) else $error("flag lost while blocked");

    property p_blocked_set;
        !global_irq_enable_o && uart_evt_i[1] |=> q[mifc_pkg::IDX_SERIAL][5];
    endproperty
    a_blocked_set: assert property (p_blocked_set) else $error("blocked event lost");

    property p_own_clear;
        take && cand_idx == mifc_pkg::SRC_EXT5 && !ext_evt_i[3] && !reg_wr_i
            |=> !q[mifc_pkg::IDX_TBEXT][7];
    endproperty
    a_own_clear: assert property (p_own_clear) else $error("line flag kept");

    property p_line_group;
        ext_evt_i[1] |=> q[mifc_pkg::IDX_GROUP][7] && q[mifc_pkg::IDX_EXTGRP][5];
    endproperty
    a_line_group: assert property (p_line_group) else $error("line group not set");

    property p_group_gate;
        take && cand_idx == mifc_pkg::SRC_GRP2 |-> q[mifc_pkg::IDX_GROUP][2]
            && (q[mifc_pkg::IDX_ATIMER][6:4] & q[mifc_pkg::IDX_ATIMER][2:0]) != 3'h0;
    endproperty
    a_group_gate: assert property (p_group_gate) else $error("group taken unenabled");
endmodule

// >>> mifc_core_model.sv
// core sequencer and return stack model facing the interrupt controller
module mifc_core_model #(
    parameter int DEPTH = 4
) (
    input  wire logic        clk_i,       // system clock
    input  wire logic        nrst_i,      // async reset, active low
    input  wire logic        slow_i,      // boundary every other cycle
    input  wire logic        call_i,      // subroutine call pushes pc
    input  wire logic        ret_req_i,   // execute return-from-irq
    input  wire logic        push_i,      // push request
    input  wire logic [15:0] push_data_i, // value to push
    input  wire logic        pop_i,       // pop request
    input  wire logic        load_i,      // pc load
    input  wire logic [15:0] load_addr_i, // new pc
    output logic             boundary_o,  // may be interrupted now
    output logic             full_o,      // return stack full
    output logic      [15:0] pc_o,        // next instruction address
    output logic             irq_return_o, // return executed
    output logic      [15:0] top_o        // top of stack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] stk [DEPTH];
    int          sp;
    ////////////////////////////////////////////////////////////////
    assign full_o = (sp == DEPTH);
    assign irq_return_o = ret_req_i;
    // empty stack shows garbage, never a stale valid entry
    assign top_o  = (sp > 0) ? stk[sp - 1] : ~pc_o;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sp <= 0;
            pc_o <= 16'h0100;
            boundary_o <= 1'b1;
        end else begin
            boundary_o <= slow_i ? ~boundary_o : 1'b1;
            if (load_i) begin
                pc_o <= load_addr_i;
            end else if (boundary_o) begin
                pc_o <= pc_o + 16'h0001;
            end
            if (pop_i && sp > 0) begin
                sp <= sp - 1;
            end else if ((push_i || call_i) && sp < DEPTH) begin
                stk[sp] <= push_i ? push_data_i : pc_o;
                sp <= sp + 1;
            end
        end
    end
endmodule

// >>> tb.sv
// self-checking bench for the interrupt flag controller
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, nrst_i, reg_wr_i, reg_rd_i, irq_en_set_i, irq_en_clr_i;
    logic [2:0]  reg_idx_i;
    logic [7:0]  reg_wdata_i, reg_rdata_o, rd;
    logic        global_irq_enable_o, push_o, pop_o, pc_load_o, wake_o;
    logic [15:0] push_data_o, pc_load_addr_o, pc_i, stack_top_i;
    logic [3:0]  irq_src_o;
    logic        boundary, full, irq_ret, slow, call, ret_req;
    logic [19:0] evt;
    logic [1:0]  tb_evt_i, uart_evt_i;
    logic [3:0]  ext_evt_i, ptimer_evt_i, vet_evt_i;
    logic [2:0]  atimer_evt_i;
    logic        serial_evt_i;
    logic [31:0] seed;
    logic [11:0] l;
    int          err_count, n_compared;
    assign {atimer_evt_i, vet_evt_i, ptimer_evt_i, serial_evt_i, uart_evt_i,
            ext_evt_i, tb_evt_i} = evt;
    ////////////////////////////////////////////////////////////////
    mifc_ctrl mifc_ctrl_inst (.clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .irq_en_set_i(irq_en_set_i), .irq_en_clr_i(irq_en_clr_i),
        .global_irq_enable_o(global_irq_enable_o), .tb_evt_i(tb_evt_i),
        .ext_evt_i(ext_evt_i), .uart_evt_i(uart_evt_i), .serial_evt_i(serial_evt_i),
        .ptimer_evt_i(ptimer_evt_i), .vet_evt_i(vet_evt_i), .atimer_evt_i(atimer_evt_i),
        .insn_boundary_i(boundary), .stack_full_i(full), .pc_i(pc_i), .irq_return_i(irq_ret),
        .stack_top_i(stack_top_i), .push_o(push_o), .push_data_o(push_data_o),
        .pop_o(pop_o), .pc_load_o(pc_load_o), .pc_load_addr_o(pc_load_addr_o),
        .irq_src_o(irq_src_o), .wake_o(wake_o));
    mifc_core_model mifc_core_model_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .slow_i(slow), .call_i(call), .ret_req_i(ret_req), .push_i(push_o),
        .push_data_i(push_data_o), .pop_i(pop_o), .load_i(pc_load_o),
        .load_addr_i(pc_load_addr_o), .boundary_o(boundary), .full_o(full),
        .pc_o(pc_i), .irq_return_o(irq_ret), .top_o(stack_top_i));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // {group or F, register index, flag bit} of event k
    function automatic logic [11:0] loc(input int k);
        if (k < 2) return {4'hF, 4'h1, 4'(k + 4)};
        if (k < 4) return {4'h3, 4'h6, 4'(k + 2)};
        if (k < 6) return {4'hF, 4'h1, 4'(k + 2)};
        if (k < 9) return {4'hF, 4'h2, 4'(k - 2)};
        if (k < 13) return {4'h0, 4'h3, 4'(k - 5)};
        if (k < 17) return {4'h1, 4'h4, 4'(k - 9)};
        return {4'h2, 4'h5, 4'(k - 13)};
    endfunction
    function automatic logic [3:0] src_of(input int k);
        if (loc(k) < 12'hF00) return 4'(loc(k) >> 8) + 4'h2;
        if (k < 2) return 4'(k + 6);
        if (k < 6) return 4'(k - 4);
        return 4'(k + 2);
    endfunction
    function automatic logic [7:0] mask(input logic [2:0] i);
        if (i == 3'h2 || i == 3'h5) return 8'h77;
        if (i == 3'h6) return 8'h33;
        return (i == 3'h7) ? 8'h00 : 8'hFF;
    endfunction
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic reg_wr(input logic [2:0] i, input logic [7:0] d);
        reg_idx_i = i;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] i);
        reg_idx_i = i;
        reg_rd_i = 1'b1;
        tick(1);
        reg_rd_i = 1'b0;
        rd = reg_rdata_o;
        tick(1);
    endtask
    // strobe held across the sweep so it never drops and rises at one instant
    task automatic fill_all(input logic [7:0] d);
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        for (int i = 0; i < 7; i++) begin
            reg_idx_i = 3'(i);
            tick(1);
        end
        reg_wr_i = 1'b0;
        tick(1);
    endtask
    task automatic clr_all();
        fill_all(8'h00);
    endtask
    task automatic fire(input logic [19:0] v);
        evt = v;
        tick(1);
        evt = 20'h0;
    endtask
    task automatic irq_en_on();
        irq_en_set_i = 1'b1;
        tick(1);
        irq_en_set_i = 1'b0;
        check(global_irq_enable_o, 16'h1);
    endtask
    task automatic no_take(input int n);
        repeat (n) begin
            tick(1);
            check(push_o, 16'h0);
        end
    endtask
    task automatic take(input logic [3:0] src);
        logic [15:0] pc_seen;
        pc_seen = pc_i;
        for (int i = 0; i < 20 && push_o !== 1'b1; i++) begin
            pc_seen = pc_i;
            tick(1);
        end
        check(push_o, 16'h1);
        check(push_data_o, pc_seen);
        check(pc_load_o, 16'h1);
        check(pc_load_addr_o, mifc_pkg::VEC_BASE + 16'(src) * mifc_pkg::VEC_STEP);
        check(irq_src_o, src);
        check(global_irq_enable_o, 16'h0);
        // the push lands at the next edge; a return before it would pop garbage
        tick(1);
        ret_req = 1'b1;
        tick(1);
        ret_req = 1'b0;
        check(pop_o, 16'h1);
        check(pc_load_addr_o, pc_seen);
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #300us;
        err_count++;
        end_sim();
    end
    initial begin
        {nrst_i, reg_wr_i, reg_rd_i, irq_en_set_i, irq_en_clr_i, slow, call, ret_req} = '0;
        {reg_idx_i, reg_wdata_i, evt, err_count, n_compared} = '0;
        seed = 32'hA83A7B41;
        tick(8);
        nrst_i = 1'b1;
        tick(1);
        for (int i = 0; i < 40; i++) begin
            l = 12'(lfsr());
            if (i < 8) reg_rd(3'(i));
            if (i < 8) check(rd, 16'h0);
            reg_wr((i < 8) ? 3'(i) : l[10:8], l[7:0]);
            reg_rd(reg_idx_i);
            check(rd, l[7:0] & mask(reg_idx_i));
        end
        clr_all();
        $display("test registers done");
        // global enable low: every event latches and wakes, nothing vectors
        for (int k = 0; k < 20; k++) begin
            l = loc(k);
            fire(20'h1 << k);
            tick(1);
            check(wake_o, 16'h1);
            check(push_o, 16'h0);
            reg_rd(l[6:4]);
            check(rd, 8'h01 << l[3:0]);
            reg_rd(3'h0);
            check(rd, (l[11:8] == 4'hF) ? 8'h00 : 8'h10 << l[11:8]);
            clr_all();
        end
        reg_wr(3'h1, 8'h10);
        tick(3);
        fire(20'h1);
        tick(1);
        check(wake_o, 16'h0);
        clr_all();
        $display("test flags done");
        for (int k = 0; k < 20; k++) begin
            l = loc(k);
            reg_wr(l[6:4], 8'h01 << (l[3:0] - 4'h4));
            irq_en_on();
            fire(20'h1 << k);
            if (l[11:8] != 4'hF) begin
                no_take(3);
                reg_wr(3'h0, 8'h11 << l[11:8]);
            end
            take(src_of(k));
            reg_rd(l[6:4]);
            check(rd, ((l[11:8] != 4'hF) ? 8'h10 : 8'h00) << (l[3:0] - 4'h4)
                | 8'h01 << (l[3:0] - 4'h4));
            reg_rd(3'h0);
            check(rd, (l[11:8] == 4'hF) ? 8'h00 : 8'h01 << l[11:8]);
            clr_all();
        end
        $display("test vectors done");
        slow = 1'b1;
        fill_all(8'h0F);
        fire(20'hFFFFF);
        for (int s = 0; s < 11; s++) begin
            irq_en_on();
            take(4'(s));
        end
        slow = 1'b0;
        clr_all();
        $display("test priority done");
        reg_wr(3'h1, 8'h01);
        call = 1'b1;
        tick(4);
        call = 1'b0;
        irq_en_on();
        fire(20'h1);
        no_take(4);
        ret_req = 1'b1;
        tick(1);
        ret_req = 1'b0;
        take(4'h6);
        irq_en_on();
        irq_en_clr_i = 1'b1;
        tick(1);
        irq_en_clr_i = 1'b0;
        check(global_irq_enable_o, 16'h0);
        $display("test stack done");
        end_sim();
    end
endmodule
